// ### hdl/dpicu_top.sv
// Command decoder for parameter-in commands, with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// (RULE1) Opcode 00 sets and returns bad-opcode flag
// (RULE2) Fault-clear keeps only still-active fault bits
// (RULE3) Fault-clear drops alert only when faults gone
// (RULE4) Alert-clear drops alert; only recurrence re-raises
// (RULE5) Seek moves to target, offset to none
// (RULE6) Out-of-range target: alert and bad-argument
// (RULE7) Every finished seek raises alert
// (RULE8) Rezero: cylinder zero, nominal strobe, no offset
// (RULE9) 0D/0E return detail octets, change nothing
// (RULE10) Opcode 0F returns status, pure no-op
// (RULE11) Unimplemented optional opcode: alert, bad-opcode
// (RULE12) Opcode 10 returns selected attribute byte
// (RULE13) Opcode 11 raises alert only
// (RULE14) Reserve/release need more than one port
// (RULE15) Reserved: others get status opcodes only
// (RULE16) Selection reserves implicitly; explicit until release
// (RULE17) Common status per port, cleared per port
// (RULE18) Gate drop with all lines: forced release
// (RULE19) Reserve sets detail-two bits 2 and 4
// (RULE20) Release clears reservation bits everywhere
// (RULE21) Selective reset clears, then init bit, alert
// (RULE22) Landing seek: not-ready, alert, fail bit
// (RULE23) Attribute number holds until reloaded
// (RULE24) Unknown mandatory-range opcode treated as unimplemented
module dpicu_top #(
  parameter int          NP  = 2,
  parameter int          PW  = 1,
  parameter int          FW  = 4,
  parameter logic [15:0] LZC = 16'hFFFF
) (
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          cmdValid,
  input  wire logic [7:0]    cmdOpcode,
  input  wire logic [PW-1:0] cmdPort,
  output logic               cmdReady,
  output logic               replyValid,
  output logic [7:0]         replyOctet,
  output logic [PW-1:0]      replyPort,
  input  wire logic [NP-1:0] portGate,
  input  wire logic [NP-1:0] portSelect,
  input  wire logic [7:0]    commandLines,
  input  wire logic [FW-1:0] faultCause,
  output logic               seekStart,
  output logic [15:0]        seekCyl,
  input  wire logic          seekDone,
  input  wire logic          seekFail,
  output logic [NP-1:0]      hostAlert,
  output logic [7:0]         readStrobeSetting,
  output logic [7:0]         headOffsetSetting
);
  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_INIT} dpicu_state_t;

  // Bus slave state
  logic        awHeld, wHeld, next_awHeld, next_wHeld, wrFire;
  logic [7:0]  awAddr, next_awAddr;
  logic [31:0] wData, next_wData, rdWord;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wrKnown;

  // Command state
  dpicu_state_t state, next_state;
  logic [7:0]    primSt [NP];
  logic [7:0]    next_primSt [NP];
  logic [7:0]    det1 [NP];
  logic [7:0]    next_det1 [NP];
  logic [7:0]    det2 [NP];
  logic [7:0]    next_det2 [NP];
  logic [FW-1:0] faultLat [NP];
  logic [FW-1:0] next_faultLat [NP];
  logic [FW-1:0] faultPrev;
  logic [NP-1:0] gatePrev, next_hostAlert, alertSet;
  logic          resvValid, resvExplicit, next_resvValid, next_resvExplicit;
  logic [PW-1:0] resvPort, next_resvPort, operPort, next_operPort;
  logic          landing, next_landing;
  logic [15:0]   targetCyl, next_targetCyl, cylLimit, next_cylLimit;
  logic [15:0]   curCyl, next_curCyl, next_seekCyl;
  logic [7:0]    attrNum, next_attrNum, attrData;
  logic [7:0]    next_strobe, next_offset, next_replyOctet;
  logic          next_replyValid, next_seekStart, cmdFire, refuse, isStatusOp;
  logic [7:0]    det1Sel;

  assign cmdFire    = cmdValid && cmdReady;
  assign isStatusOp = (cmdOpcode == dpicu_pkg::OP_DETAIL_TWO) ||
                      (cmdOpcode == dpicu_pkg::OP_DETAIL_ONE) ||
                      (cmdOpcode == dpicu_pkg::OP_STATUS);
  assign refuse     = resvValid && (resvPort != cmdPort) && !isStatusOp; // RULE15
  assign det1Sel    = det1[cmdPort];
  assign wrFire     = awHeld && wHeld && !s_axi_bvalid;
  assign wrKnown    = (awAddr <= dpicu_pkg::REG_SETUP) && (awAddr[1:0] == 2'h0);

  // Attribute byte follows the held attribute number
  dpicu_attr_mem #(.AW(8), .DW(8)) uAttr (
    .clk_sys (clk_sys),
    .wrEn    (wrFire && awAddr == dpicu_pkg::REG_ATTRW),
    .wrAddr  (attrNum),
    .wrData  (wData[7:0]),
    .rdAddr  (attrNum),
    .rdData  (attrData)
  );

  // Register read mux, unmapped words read zero
  always_comb begin
    case (s_axi_araddr)
      dpicu_pkg::REG_TARGET: rdWord = {16'h0000, targetCyl};
      dpicu_pkg::REG_LIMIT:  rdWord = {16'h0000, cylLimit};
      dpicu_pkg::REG_ATTRN:  rdWord = {24'h000000, attrNum};
      dpicu_pkg::REG_ATTRW:  rdWord = {24'h000000, attrData};
      dpicu_pkg::REG_STATUS: rdWord = {6'h00, state, det2[0], det1[0], primSt[0]};
      dpicu_pkg::REG_POS:    rdWord = {14'h0000, hostAlert[1:0], curCyl};
      dpicu_pkg::REG_SETUP:  rdWord = {16'h0000, headOffsetSetting, readStrobeSetting};
      default:               rdWord = 32'h00000000;
    endcase
  end

  // AXI4-Lite handshakes; address and data taken in either order
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
    end
    if (wrFire) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = wrKnown ? dpicu_pkg::RESP_OKAY : dpicu_pkg::RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rdWord;
      next_rresp  = (s_axi_araddr <= dpicu_pkg::REG_SETUP && s_axi_araddr[1:0] == 2'h0) ?
                    dpicu_pkg::RESP_OKAY : dpicu_pkg::RESP_SLVERR;
    end
    next_awready = !next_awHeld;
    next_wready  = !next_wHeld;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      awHeld <= 1'b0; awAddr <= 8'h00; wHeld <= 1'b0; wData <= 32'h00000000;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0; s_axi_rresp <= 2'h0; s_axi_rdata <= 32'h00000000;
    end else begin
      awHeld <= next_awHeld; awAddr <= next_awAddr; wHeld <= next_wHeld; wData <= next_wData;
      s_axi_awready <= next_awready; s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid; s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid; s_axi_rresp <= next_rresp; s_axi_rdata <= next_rdata;
    end
  end

  // Command decode; clears first, hardware events OR in last so a set wins
  always_comb begin
    next_state = state;
    next_primSt = primSt;
    next_det1 = det1;
    next_det2 = det2;
    next_faultLat = faultLat;
    next_hostAlert = hostAlert;
    alertSet = '0;
    next_resvValid = resvValid;
    next_resvExplicit = resvExplicit;
    next_resvPort = resvPort;
    next_operPort = operPort;
    next_landing = landing;
    next_targetCyl = targetCyl;
    next_cylLimit = cylLimit;
    next_curCyl = curCyl;
    next_seekCyl = seekCyl;
    next_attrNum = attrNum;
    next_strobe = readStrobeSetting;
    next_offset = headOffsetSetting;
    next_seekStart = 1'b0;
    next_replyValid = 1'b0;
    next_replyOctet = replyOctet;
    // Register writes from software; attribute number holds until rewritten
    if (wrFire && awAddr == dpicu_pkg::REG_TARGET) next_targetCyl = wData[15:0];
    if (wrFire && awAddr == dpicu_pkg::REG_LIMIT) next_cylLimit = wData[15:0];
    if (wrFire && awAddr == dpicu_pkg::REG_ATTRN) next_attrNum = wData[7:0]; // RULE23
    if (wrFire && awAddr == dpicu_pkg::REG_SETUP) begin
      next_strobe = wData[7:0];
      next_offset = wData[15:8];
    end
    // Implicit reservation follows selection while no explicit one holds
    if (!resvValid) begin
      for (int p = NP - 1; p >= 0; p--) begin
        if (portSelect[p]) begin
          next_resvValid = 1'b1; // RULE16
          next_resvPort = PW'(p);
        end
      end
    end else if (!resvExplicit && !portSelect[resvPort]) begin
      next_resvValid = 1'b0; // RULE16
    end
    if (cmdFire) begin
      next_operPort = cmdPort;
      next_replyValid = 1'b1;
      if (refuse) begin
        next_det1[cmdPort][dpicu_pkg::D1_REFUSED] = 1'b1; // RULE15
        alertSet[cmdPort] = 1'b1;
      end else begin
        case (cmdOpcode)
          dpicu_pkg::OP_BAD_REPORT: next_primSt[cmdPort][dpicu_pkg::PS_BAD_OPCODE] = 1'b1; // RULE1
          dpicu_pkg::OP_FAULT_CLR: begin
            next_faultLat[cmdPort] = faultCause; // RULE2 RULE17
            if (faultCause == '0) next_hostAlert[cmdPort] = 1'b0; // RULE3
          end
          dpicu_pkg::OP_ALERT_CLR: next_hostAlert[cmdPort] = 1'b0; // RULE4
          dpicu_pkg::OP_SEEK: begin
            next_offset = dpicu_pkg::OFFSET_NONE; // RULE5
            if (targetCyl >= cylLimit) begin
              next_primSt[cmdPort][dpicu_pkg::PS_BAD_ARG] = 1'b1; // RULE6
              alertSet[cmdPort] = 1'b1;
            end else begin
              next_seekCyl = targetCyl; // RULE5
              next_seekStart = 1'b1;
              next_landing = 1'b0;
              next_state = ST_SEEK;
            end
          end
          dpicu_pkg::OP_REZERO: begin
            next_strobe = dpicu_pkg::STROBE_NOMINAL; // RULE8
            next_offset = dpicu_pkg::OFFSET_NONE;
            next_seekCyl = 16'h0000;
            next_seekStart = 1'b1;
            next_landing = 1'b0;
            next_state = ST_SEEK;
          end
          dpicu_pkg::OP_DETAIL_TWO, dpicu_pkg::OP_DETAIL_ONE,
          dpicu_pkg::OP_STATUS, dpicu_pkg::OP_ATTR_REP: ; // RULE9 RULE10 RULE12
          dpicu_pkg::OP_ALERT_SET: alertSet[cmdPort] = 1'b1; // RULE13
          dpicu_pkg::OP_RESERVE, dpicu_pkg::OP_RELEASE: begin
            if (NP < 2) begin
              next_primSt[cmdPort][dpicu_pkg::PS_BAD_OPCODE] = 1'b1; // RULE14
              alertSet[cmdPort] = 1'b1;
            end else begin
              for (int p = 0; p < NP; p++) begin
                next_det2[p][dpicu_pkg::D2_RESV_HERE] = 1'b0; // RULE20
                next_det2[p][dpicu_pkg::D2_RESV_ELSE] = 1'b0;
                if (cmdOpcode == dpicu_pkg::OP_RESERVE) begin
                  next_det2[p][dpicu_pkg::D2_RESV_HERE] = (PW'(p) == cmdPort); // RULE19
                  next_det2[p][dpicu_pkg::D2_RESV_ELSE] = (PW'(p) != cmdPort);
                end
              end
              next_resvValid = (cmdOpcode == dpicu_pkg::OP_RESERVE) || portSelect[cmdPort];
              next_resvExplicit = (cmdOpcode == dpicu_pkg::OP_RESERVE);
              next_resvPort = cmdPort;
            end
          end
          dpicu_pkg::OP_SEL_RESET: begin
            next_primSt[cmdPort] = 8'h00; // RULE21
            next_det1[cmdPort] = 8'h00;
            next_faultLat[cmdPort] = '0;
            next_hostAlert[cmdPort] = 1'b0;
            next_state = ST_INIT;
          end
          dpicu_pkg::OP_LANDING: begin
            next_primSt[cmdPort][dpicu_pkg::PS_NOT_READY] = 1'b1; // RULE22
            next_seekCyl = LZC;
            next_seekStart = 1'b1;
            next_landing = 1'b1;
            next_state = ST_SEEK;
          end
          default: begin
            next_primSt[cmdPort][dpicu_pkg::PS_BAD_OPCODE] = 1'b1; // RULE11 RULE24
            alertSet[cmdPort] = 1'b1;
          end
        endcase
      end
    end
    // Motion and initial-state completion
    case (state)
      ST_SEEK: begin
        if (seekDone || seekFail) begin
          next_state = ST_IDLE;
          alertSet[operPort] = 1'b1; // RULE7 RULE8 RULE22
          next_primSt[operPort][dpicu_pkg::PS_NOT_READY] = 1'b0;
          if (seekDone && !landing) next_curCyl = seekCyl;
          if (seekFail && landing) next_det1[operPort][dpicu_pkg::D1_LAND_FAIL] = 1'b1; // RULE22
        end
      end
      ST_INIT: begin
        next_strobe = dpicu_pkg::STROBE_NOMINAL;
        next_offset = dpicu_pkg::OFFSET_NONE;
        next_det2[operPort][dpicu_pkg::D2_INIT_DONE] = 1'b1; // RULE21
        alertSet[operPort] = 1'b1;
        next_state = ST_IDLE;
      end
      default: ;
    endcase
    // Forced release by a falling gate with every command line active
    for (int p = 0; p < NP; p++) begin
      if (resvValid && gatePrev[p] && !portGate[p] && (&commandLines) &&
          PW'(p) != resvPort) begin
        next_resvValid = 1'b0; // RULE18
        next_resvExplicit = 1'b0;
        next_det2[resvPort][dpicu_pkg::D2_SEIZED] = 1'b1;
        alertSet[resvPort] = 1'b1;
        for (int q = 0; q < NP; q++) begin
          next_det2[q][dpicu_pkg::D2_RESV_HERE] = 1'b0;
          next_det2[q][dpicu_pkg::D2_RESV_ELSE] = 1'b0;
        end
      end
    end
    // Common fault causes reach every port; a new cause alerts again
    for (int p = 0; p < NP; p++) begin
      next_faultLat[p] = next_faultLat[p] | faultCause; // RULE17 RULE2
      if ((faultCause & ~faultPrev) != '0) alertSet[p] = 1'b1; // RULE4
    end
    next_hostAlert = next_hostAlert | alertSet;
    // Reply built from updated state so clears show in the returned octet
    if (cmdFire) begin
      next_replyOctet = next_primSt[cmdPort];
      next_replyOctet[dpicu_pkg::PS_FAULT] = |next_faultLat[cmdPort];
      next_replyOctet[dpicu_pkg::PS_SEEKING] = (next_state == ST_SEEK);
      if (!refuse && cmdOpcode == dpicu_pkg::OP_DETAIL_TWO) next_replyOctet = det2[cmdPort];
      if (!refuse && cmdOpcode == dpicu_pkg::OP_DETAIL_ONE) next_replyOctet = det1[cmdPort];
      if (!refuse && cmdOpcode == dpicu_pkg::OP_ATTR_REP) next_replyOctet = attrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= ST_IDLE;
      for (int p = 0; p < NP; p++) begin
        primSt[p] <= 8'h00; det1[p] <= 8'h00; det2[p] <= 8'h00; faultLat[p] <= '0;
      end
      faultPrev <= '0; gatePrev <= '0; hostAlert <= '0;
      resvValid <= 1'b0; resvExplicit <= 1'b0; resvPort <= '0; operPort <= '0;
      landing <= 1'b0; targetCyl <= 16'h0000; cylLimit <= dpicu_pkg::CYL_LIMIT_RST;
      curCyl <= 16'h0000; seekCyl <= 16'h0000; attrNum <= 8'h00;
      readStrobeSetting <= dpicu_pkg::STROBE_NOMINAL;
      headOffsetSetting <= dpicu_pkg::OFFSET_NONE;
      seekStart <= 1'b0; replyValid <= 1'b0; replyOctet <= 8'h00; replyPort <= '0;
      cmdReady <= 1'b0;
    end else begin
      state <= next_state;
      primSt <= next_primSt; det1 <= next_det1; det2 <= next_det2; faultLat <= next_faultLat;
      faultPrev <= faultCause; gatePrev <= portGate; hostAlert <= next_hostAlert;
      resvValid <= next_resvValid; resvExplicit <= next_resvExplicit;
      resvPort <= next_resvPort; operPort <= next_operPort;
      landing <= next_landing; targetCyl <= next_targetCyl; cylLimit <= next_cylLimit;
      curCyl <= next_curCyl; seekCyl <= next_seekCyl; attrNum <= next_attrNum;
      readStrobeSetting <= next_strobe; headOffsetSetting <= next_offset;
      seekStart <= next_seekStart; replyValid <= next_replyValid;
      replyOctet <= next_replyOctet; replyPort <= next_operPort;
      cmdReady <= (next_state == ST_IDLE) && !(cmdFire && next_state != state);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  bad_op_reply_a: assert property (cmdFire && !refuse && cmdOpcode == 8'h00 |=> // RULE1
    replyValid && replyOctet[0]) else $error("bad opcode flag missing in reply");
  range_alert_a: assert property (cmdFire && !refuse && cmdOpcode == 8'h03 && // RULE6
    targetCyl >= cylLimit |=> hostAlert[operPort] && replyOctet[1] && !seekStart)
    else $error("out-of-range seek not flagged");
  seek_offset_a: assert property (cmdFire && !refuse && cmdOpcode == 8'h03 |=> // RULE5
    headOffsetSetting == 8'h00) else $error("seek left head offset");
  seek_alert_a: assert property (state == ST_SEEK && seekDone |=> // RULE7
    hostAlert[operPort] && state == ST_IDLE) else $error("seek end gave no alert");
  rezero_set_a: assert property (cmdFire && !refuse && cmdOpcode == 8'h04 |=> // RULE8
    seekStart && seekCyl == 16'h0000 && readStrobeSetting == 8'h00)
    else $error("rezero settings wrong");
  detail_reply_a: assert property (cmdFire && !refuse && cmdOpcode == 8'h0E |=> // RULE9
    replyOctet == $past(det1Sel)) else $error("detail one reply wrong");
  alert_set_a: assert property (cmdFire && !refuse && cmdOpcode == 8'h11 |=> // RULE13
    hostAlert[operPort] && state == ST_IDLE) else $error("set alert failed");
  refuse_flag_a: assert property (cmdFire && refuse |=> // RULE15
    det1[operPort][6] && hostAlert[operPort]) else $error("refusal not flagged");
  init_seq_a: assert property (cmdFire && !refuse && cmdOpcode == 8'h14 |=> // RULE21
    state == ST_INIT ##1 det2[operPort][0] && hostAlert[operPort])
    else $error("selective reset sequence wrong");

  seek_done_c: cover property (state == ST_SEEK && seekDone);
  land_fail_c: cover property (state == ST_SEEK && landing && seekFail);
  refuse_c:    cover property (cmdFire && refuse);
  reserve_c:   cover property (cmdFire && cmdOpcode == 8'h12 ##[1:20] !resvValid);
endmodule : dpicu_top

// ### hdl/dpicu_pkg.sv
// Constants shared by the disk parameter-in command unit
package dpicu_pkg;
  // Opcodes
  localparam logic [7:0] OP_BAD_REPORT = 8'h00;
  localparam logic [7:0] OP_FAULT_CLR  = 8'h01;
  localparam logic [7:0] OP_ALERT_CLR  = 8'h02;
  localparam logic [7:0] OP_SEEK       = 8'h03;
  localparam logic [7:0] OP_REZERO     = 8'h04;
  localparam logic [7:0] OP_DETAIL_TWO = 8'h0D;
  localparam logic [7:0] OP_DETAIL_ONE = 8'h0E;
  localparam logic [7:0] OP_STATUS     = 8'h0F;
  localparam logic [7:0] OP_ATTR_REP   = 8'h10;
  localparam logic [7:0] OP_ALERT_SET  = 8'h11;
  localparam logic [7:0] OP_RESERVE    = 8'h12;
  localparam logic [7:0] OP_RELEASE    = 8'h13;
  localparam logic [7:0] OP_SEL_RESET  = 8'h14;
  localparam logic [7:0] OP_LANDING    = 8'h15;
  // Primary status octet bits
  localparam int PS_BAD_OPCODE = 0;
  localparam int PS_BAD_ARG    = 1;
  localparam int PS_NOT_READY  = 2;
  localparam int PS_FAULT      = 3;
  localparam int PS_SEEKING    = 4;
  // Detail status one and two bits
  localparam int D1_LAND_FAIL  = 0;
  localparam int D1_REFUSED    = 6;
  localparam int D2_INIT_DONE  = 0;
  localparam int D2_RESV_HERE  = 2;
  localparam int D2_RESV_ELSE  = 4;
  localparam int D2_SEIZED     = 5;
  // Register byte offsets
  localparam logic [7:0] REG_TARGET = 8'h00;
  localparam logic [7:0] REG_LIMIT  = 8'h04;
  localparam logic [7:0] REG_ATTRN  = 8'h08;
  localparam logic [7:0] REG_ATTRW  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_POS    = 8'h14;
  localparam logic [7:0] REG_SETUP  = 8'h18;
  // Reset values and bus response codes
  localparam logic [15:0] CYL_LIMIT_RST  = 16'h0400;
  localparam logic [7:0]  STROBE_NOMINAL = 8'h00;
  localparam logic [7:0]  OFFSET_NONE    = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : dpicu_pkg

// ### hdl/dpicu_attr_mem.sv
// Attribute table storage with registered read data
`timescale 1ns/1ps
module dpicu_attr_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);
  logic [DW-1:0] mem [2**AW];

  // Read follows the address one cycle later
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : dpicu_attr_mem

// ### testbench/dpicu_servo_model.sv
// Servo stand-in answering seek starts after a varying delay
`timescale 1ns/1ps
module dpicu_servo_model (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        seekStart,
  input  wire logic        failReq,
  output logic             seekDone,
  output logic             seekFail
);
  logic [3:0] cnt;
  logic       busy;
  // Completion pulses never overlap a new start; fail only when asked
  always @(posedge clk_sys) begin
    seekDone <= 1'b0;
    seekFail <= 1'b0;
    if (!rstn) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
    end else if (seekStart) begin
      busy <= 1'b1;
      cnt  <= 4'(2 + $urandom % 6);
    end else if (busy) begin
      if (cnt == 4'h0) begin
        busy     <= 1'b0;
        seekDone <= 1'b1;
        seekFail <= failReq;
      end else cnt <= cnt - 4'h1;
    end
  end
endmodule : dpicu_servo_model

// ### testbench/disk_parameter_in_command_unit_tb.sv
// Self-checking bench for the parameter-in command unit
`timescale 1ns/1ps
module disk_parameter_in_command_unit_tb;
  logic clk_sys, rstn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, cmdValid, cmdReady;
  logic replyValid, cmdPort, seekStart, seekDone, seekFail, failReq, rp;
  logic [7:0] awa, ara, cmdOpcode, replyOctet, strobe, offset, lines;
  logic [31:0] wd, rd, got;
  logic [1:0] bresp, rresp, alert, gotResp, gate, sel;
  logic [3:0] fault;
  logic [15:0] seekCyl;
  logic [16:0] expq[$], e;
  logic [7:0] r;
  int fail_count = 0, num_checks = 0;
  dpicu_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .cmdValid(cmdValid),
    .cmdOpcode(cmdOpcode), .cmdPort(cmdPort), .cmdReady(cmdReady), .replyValid(replyValid),
    .replyOctet(replyOctet), .replyPort(rp), .portGate(gate), .portSelect(sel),
    .commandLines(lines), .faultCause(fault), .seekStart(seekStart), .seekCyl(seekCyl),
    .seekDone(seekDone), .seekFail(seekFail), .hostAlert(alert),
    .readStrobeSetting(strobe), .headOffsetSetting(offset));
  dpicu_servo_model u_servo (.clk_sys(clk_sys), .rstn(rstn), .seekStart(seekStart),
    .failReq(failReq), .seekDone(seekDone), .seekFail(seekFail));
  // Clock and watchdog
  initial begin clk_sys = 0; forever #2 clk_sys = ~clk_sys; end
  initial begin #40000; fail_count++; final_report(); end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, x); end
  endtask : chk
  // Reply watcher: oldest note against each reply pulse
  always @(posedge clk_sys) if (replyValid === 1'b1) begin
    e = (expq.size() > 0) ? expq.pop_front() : 17'h000FF;
    chk(32'(replyOctet & e[15:8]), 32'(e[7:0]));
    chk(32'(rp), 32'(e[16]));
  end
  task automatic cmd(input logic [7:0] op, input logic p, input logic [7:0] m, input logic [7:0] v);
    @(posedge clk_sys);
    cmdOpcode <= op; cmdPort <= p; cmdValid <= 1'b1;
    do @(posedge clk_sys); while (cmdReady !== 1'b1);
    expq.push_back({p, m, v}); cmdValid <= 1'b0;
  endtask : cmd
  // Waits out seeks and the init cycle; hang is caught by the watchdog
  task automatic idle();
    do @(posedge clk_sys); while (cmdReady !== 1'b1);
  endtask : idle
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0; w = 0;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (awv && awr) begin aw = 1; awv <= 1'b0; end
      if (wv && wr) begin w = 1; wv <= 1'b0; end
    end
    do @(posedge clk_sys); while (bv !== 1'b1);
    gotResp = bresp;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    ara <= a; arv <= 1'b1;
    do @(posedge clk_sys); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk_sys); while (rv !== 1'b1);
    got = rd; gotResp = rresp;
  endtask : axr
  initial begin
    {awv, wv, arv, cmdValid, cmdPort, failReq} = '0;
    {br, rr} = 2'h3;
    {awa, ara, wd, cmdOpcode, gate, sel, fault, lines} = '0; rstn = 0;
    void'($urandom(32'hc06998ca));
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cmd(8'h0F, 0, 8'hFF, 8'h00);
    cmd(8'h00, 0, 8'hFF, 8'h01);
    cmd(8'h0F, 0, 8'hFF, 8'h01);
    cmd(8'h14, 0, 8'hFF, 8'h00);
    idle(); chk(alert[0], 1);
    cmd(8'h0D, 0, 8'h01, 8'h01);
    cmd(8'h02, 0, 8'hFF, 8'h00); idle(); chk(alert[0], 0);
    cmd(8'h11, 0, 8'hFF, 8'h00); idle(); chk(alert[0], 1);
    cmd(8'h02, 0, 8'hFF, 8'h00);
    axw(8'h18, 32'h3355); axw(8'h00, 32'h5); chk(gotResp, 2'h0);
    cmd(8'h03, 0, 8'h10, 8'h10); idle(); chk(alert[0], 1);
    chk({strobe, offset}, 16'h5500);
    chk(seekCyl, 16'h0005);
    axr(8'h14); chk(got, 32'h00010005);
    axr(8'hFC); chk(gotResp, 2'h2);
    cmd(8'h02, 0, 8'hFF, 8'h00); axw(8'h00, 32'h0400);
    cmd(8'h03, 0, 8'h02, 8'h02); idle(); chk(alert[0], 1);
    cmd(8'h04, 0, 8'h10, 8'h10); idle(); chk({strobe, offset}, 0);
    axr(8'h14); chk(got[15:0], 0);
    cmd(8'h05, 0, 8'h01, 8'h01); cmd(8'h0C, 0, 8'h01, 8'h01);
    cmd(8'h20, 0, 8'h01, 8'h01);
    r = 8'($urandom);
    axw(8'h08, 32'h3); axw(8'h0C, 32'(r));
    cmd(8'h10, 0, 8'hFF, r);
    axw(8'h0C, 32'(~r)); cmd(8'h10, 0, 8'hFF, ~r);
    cmd(8'h12, 0, 8'hFF, 8'h03); cmd(8'h0D, 0, 8'h04, 8'h04);
    cmd(8'h0D, 1, 8'h10, 8'h10); cmd(8'h11, 1, 8'hFF, 8'h00);
    cmd(8'h0E, 1, 8'h40, 8'h40);
    cmd(8'h13, 0, 8'hFF, 8'h03); cmd(8'h0D, 0, 8'h14, 8'h00);
    cmd(8'h0D, 1, 8'h14, 8'h00);
    failReq <= 1'b1;
    cmd(8'h15, 0, 8'h04, 8'h04); idle(); chk(alert[0], 1);
    cmd(8'h0E, 0, 8'h01, 8'h01);
    cmd(8'h11, 1, 8'hFF, 8'h00); sel <= 2'h1;
    cmd(8'h02, 1, 8'hFF, 8'h00); idle(); chk(alert[1], 1);
    gate <= 2'h2; lines <= 8'hFF; @(posedge clk_sys); gate <= 2'h0;
    cmd(8'h0D, 0, 8'h20, 8'h20);
    sel <= 2'h0; lines <= 8'h00; fault <= 4'h1;
    cmd(8'h0F, 1, 8'h08, 8'h08); cmd(8'h01, 0, 8'h08, 8'h08);
    idle(); chk(alert[0], 1); fault <= 4'h0;
    cmd(8'h01, 0, 8'h08, 8'h00); idle(); chk(alert[0], 0);
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule : disk_parameter_in_command_unit_tb
